// ==== mfs_ctrl_model.sv ====
// Controller model that drives the parameter port of the monitor bank.
// Assumes the bench calls its tasks and changes nothing else on this port.
`timescale 1ns/10ps
module mfs_ctrl_model (
    input  wire logic        core_clk,
    output logic             paramWrEn,
    output logic             paramRdEn,
    output logic [11:0]      paramAddr,
    output logic [15:0]      paramWrData
);
    // Idle port from time zero
    initial begin
        paramWrEn   = 1'b0;
        paramRdEn   = 1'b0;
        paramAddr   = 12'h000;
        paramWrData = 16'h0000;
    end

    // One access per falling edge, held until the next call or idle
    task automatic acc(input logic wr, input logic rd, input logic [11:0] a,
                       input logic [15:0] d);
        @(negedge core_clk);
        paramWrEn   = wr;
        paramRdEn   = rd;
        paramAddr   = a;
        paramWrData = d;
    endtask : acc

    // Released lines show the inverse so stale values never look valid
    task automatic idle();
        @(negedge core_clk);
        paramWrEn   = 1'b0;
        paramRdEn   = 1'b0;
        paramAddr   = ~paramAddr;
        paramWrData = ~paramWrData;
    endtask : idle
endmodule : mfs_ctrl_model

// ==== mfs_field_mux.sv ====
// Content choice for one monitor field, purely combinational.
// Assumes selectors are stable and item values sampled by the caller.
`timescale 1ns/10ps
`include "mfs_params.svh"
module mfs_field_mux (
    mfs_sel_if.sink                 sel,
    input  wire logic [39:0][31:0]  itemValues,
    input  wire logic [31:0]        targetPosition,
    input  wire logic [31:0]        optionItemOne,
    input  wire logic [31:0]        optionItemTwo,
    output logic      [31:0]        fieldValue
);
    logic [31:0] itemWord;
    logic [31:0] cmnOneWord;
    logic [31:0] cmnTwoWord;

    // Item code lookup, unlisted codes give zero
    always_comb begin
        itemWord = 32'h0000_0000;
        if (sel.itemSel <= `MFS_ITEM_MAX && sel.itemSel != `MFS_ITEM_HOLE) begin // R1 R2 R3 R10
            itemWord = itemValues[sel.itemSel[5:0]];
        end
    end

    // Common monitor one lookup
    always_comb begin
        case (sel.commonOneSel) // R8
            `MFS_CMN_TARGET_POS:    cmnOneWord = targetPosition;
            `MFS_CMN_INT_CMD_POS:   cmnOneWord = itemValues[`MFS_ITEM_INT_CMD_POS];
            `MFS_CMN_POS_OFFSET:    cmnOneWord = itemValues[`MFS_ITEM_POS_OFFSET];
            `MFS_CMN_TARGET_SPEED:  cmnOneWord = itemValues[`MFS_ITEM_TARGET_SPEED];
            `MFS_CMN_SPEED_CEILING: cmnOneWord = itemValues[`MFS_ITEM_SPEED_CEILING];
            default:                cmnOneWord = 32'h0000_0000; // R10
        endcase
    end

    // Common monitor two lookup
    always_comb begin
        case (sel.commonTwoSel) // R9
            `MFS_CMN_TORQUE_CEILING: cmnTwoWord = itemValues[`MFS_ITEM_TORQUE_CEILING];
            `MFS_CMN_OPER_STATUS:    cmnTwoWord = itemValues[`MFS_ITEM_OPER_STATUS];
            `MFS_CMN_INIT_POS_LOW:   cmnTwoWord = itemValues[`MFS_ITEM_INIT_POS_LOW];
            `MFS_CMN_INIT_POS_HIGH:  cmnTwoWord = itemValues[`MFS_ITEM_INIT_POS_HIGH];
            default:                 cmnTwoWord = 32'h0000_0000; // R10
        endcase
    end

    // Route codes override the item selector
    always_comb begin
        fieldValue = itemWord;
        if (sel.directSel[15:4] == 12'h000) begin
            case (sel.directSel[3:0]) // R7
                mfs_pkg::MFS_ROUTE_CMN_ONE: fieldValue = cmnOneWord;
                mfs_pkg::MFS_ROUTE_CMN_TWO: fieldValue = cmnTwoWord;
                mfs_pkg::MFS_ROUTE_OPT_ONE: fieldValue = optionItemOne;
                mfs_pkg::MFS_ROUTE_OPT_TWO: fieldValue = optionItemTwo;
                default:                    fieldValue = itemWord;
            endcase
        end
    end
endmodule : mfs_field_mux

// ==== mfs_monitor_select.sv ====
// Register bank that picks what the two fixed monitor fields carry.
// Assumes a single-word parameter port driven synchronously to core_clk.
//
// Functional notes
// R1 - Field one item selector, codes 0-17, default 1
// R2 - Field two item selector, same codes, default 0
// R3 - Item codes 18 to 39 select further quantities
// R4 - Item selector changes apply only after restart
// R5 - Controller rewrites field and common selectors too
// R6 - Field one direct codes 0H-6H, default 1H
// R7 - CH/DH route common, EH/FH route option
// R8 - Common one selector codes 0-4, default 0
// R9 - Common two codes 5,6,8,9, default 0
// R10 - Unlisted codes rejected, field reads zero
`timescale 1ns/10ps
`include "mfs_params.svh"
module mfs_monitor_select (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              clkEn,
    input  wire logic              powerRestart,
    input  wire logic              paramWrEn,
    input  wire logic              paramRdEn,
    input  wire logic [11:0]       paramAddr,
    input  wire logic [15:0]       paramWrData,
    output logic      [15:0]       paramRdData,
    output logic                   paramAck,
    output logic                   paramErr,
    output logic                   restartPending,
    input  wire logic [39:0][31:0] itemValues,
    input  wire logic [31:0]       targetPosition,
    input  wire logic [31:0]       optionItemOne,
    input  wire logic [31:0]       optionItemTwo,
    output logic      [31:0]       field1Data,
    output logic      [31:0]       field2Data
);
    localparam mfs_pkg::mfs_state_s RESET_STATE = '{
        itemOnePend: `MFS_RST_FIELD1_ITEM,
        itemTwoPend: `MFS_RST_FIELD2_ITEM,
        itemOneAct:  `MFS_RST_FIELD1_ITEM,
        itemTwoAct:  `MFS_RST_FIELD2_ITEM,
        directOne:   `MFS_RST_FIELD1_DIRECT,
        directTwo:   `MFS_RST_FIELD2_DIRECT,
        commonOne:   `MFS_RST_COMMON_ONE,
        commonTwo:   `MFS_RST_COMMON_TWO,
        rdData:      16'h0000,
        ack:         1'b0,
        err:         1'b0,
        pending:     1'b0,
        field1:      32'h0000_0000,
        field2:      32'h0000_0000
    };

    mfs_pkg::mfs_state_s stateQ;
    mfs_pkg::mfs_state_s stateD;
    logic [31:0]         field1Value;
    logic [31:0]         field2Value;
    logic                addrHit;
    logic                codeOk;
    logic [15:0]         readWord;

    mfs_sel_if selOne ();
    mfs_sel_if selTwo ();

    // Selector bundles seen by the muxes, item selectors from the active copy
    assign selOne.itemSel      = stateQ.itemOneAct; // R4
    assign selOne.directSel    = stateQ.directOne;
    assign selOne.commonOneSel = stateQ.commonOne;
    assign selOne.commonTwoSel = stateQ.commonTwo;
    assign selTwo.itemSel      = stateQ.itemTwoAct; // R4
    assign selTwo.directSel    = stateQ.directTwo;
    assign selTwo.commonOneSel = stateQ.commonOne;
    assign selTwo.commonTwoSel = stateQ.commonTwo;

    mfs_field_mux fieldOneMux (
        .sel            (selOne),
        .itemValues     (itemValues),
        .targetPosition (targetPosition),
        .optionItemOne  (optionItemOne),
        .optionItemTwo  (optionItemTwo),
        .fieldValue     (field1Value)
    );

    mfs_field_mux fieldTwoMux (
        .sel            (selTwo),
        .itemValues     (itemValues),
        .targetPosition (targetPosition),
        .optionItemOne  (optionItemOne),
        .optionItemTwo  (optionItemTwo),
        .fieldValue     (field2Value)
    );

    // Address decode, code check and read word
    always_comb begin
        addrHit  = 1'b1;
        codeOk   = 1'b0;
        readWord = 16'h0000;
        if (paramAddr == `MFS_ADDR_FIELD1_ITEM) begin
            readWord = stateQ.itemOnePend;
            codeOk   = paramWrData <= `MFS_ITEM_MAX && paramWrData != `MFS_ITEM_HOLE; // R10
        end else if (paramAddr == `MFS_ADDR_FIELD2_ITEM) begin
            readWord = stateQ.itemTwoPend;
            codeOk   = paramWrData <= `MFS_ITEM_MAX && paramWrData != `MFS_ITEM_HOLE; // R10
        end else if (paramAddr == `MFS_ADDR_FIELD1_DIRECT ||
                     paramAddr == `MFS_ADDR_FIELD2_DIRECT) begin
            readWord = (paramAddr == `MFS_ADDR_FIELD1_DIRECT) ? stateQ.directOne
                                                               : stateQ.directTwo;
            codeOk   = paramWrData <= `MFS_DIRECT_LAST_ITEM || // R6
                       (paramWrData >= `MFS_DIRECT_FIRST_ROUTE &&
                        paramWrData <= `MFS_DIRECT_LAST_ROUTE); // R7
        end else if (paramAddr == `MFS_ADDR_COMMON_ONE) begin
            readWord = stateQ.commonOne;
            codeOk   = paramWrData <= `MFS_COMMON_ONE_MAX; // R8
        end else if (paramAddr == `MFS_ADDR_COMMON_TWO) begin
            readWord = stateQ.commonTwo;
            codeOk   = paramWrData == `MFS_CMN_TORQUE_CEILING || // R9
                       paramWrData == `MFS_CMN_OPER_STATUS ||
                       paramWrData == `MFS_CMN_INIT_POS_LOW ||
                       paramWrData == `MFS_CMN_INIT_POS_HIGH;
        end else begin
            addrHit  = 1'b0;
        end
    end

    // Next state: accesses, restart commit, field capture
    always_comb begin
        stateD        = stateQ;
        stateD.ack    = paramWrEn | paramRdEn;
        stateD.err    = 1'b0;
        stateD.field1 = field1Value;
        stateD.field2 = field2Value;
        if (paramRdEn) begin
            stateD.rdData = addrHit ? readWord : 16'h0000;
            stateD.err    = ~addrHit;
        end
        // Restart promotes the stored item selectors
        if (powerRestart) begin
            stateD.itemOneAct = stateQ.itemOnePend; // R4
            stateD.itemTwoAct = stateQ.itemTwoPend; // R4
            stateD.pending    = 1'b0;
        end
        if (paramWrEn && !paramRdEn) begin
            if (!addrHit || !codeOk) begin
                stateD.err = 1'b1; // R10
            end else if (paramAddr == `MFS_ADDR_FIELD1_ITEM) begin
                stateD.itemOnePend = paramWrData; // R1 R4
                stateD.pending     = paramWrData != stateD.itemOneAct ||
                                     stateD.itemTwoPend != stateD.itemTwoAct;
            end else if (paramAddr == `MFS_ADDR_FIELD2_ITEM) begin
                stateD.itemTwoPend = paramWrData; // R2 R4
                stateD.pending     = paramWrData != stateD.itemTwoAct ||
                                     stateD.itemOnePend != stateD.itemOneAct;
            end else if (paramAddr == `MFS_ADDR_FIELD1_DIRECT) begin
                stateD.directOne = paramWrData; // R6
            end else if (paramAddr == `MFS_ADDR_FIELD2_DIRECT) begin
                stateD.directTwo = paramWrData; // R7
            end else if (paramAddr == `MFS_ADDR_COMMON_ONE) begin
                stateD.commonOne = paramWrData; // R8
            end else begin
                stateD.commonTwo = paramWrData; // R9
            end
        end else if (paramWrEn) begin
            stateD.err = 1'b1;
        end
    end

    // State register, frozen while clkEn is low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stateQ <= RESET_STATE;
        end else if (clkEn) begin
            stateQ <= stateD;
        end
    end

    // Outputs straight from the state register
    assign paramRdData    = stateQ.rdData;
    assign paramAck       = stateQ.ack;
    assign paramErr       = stateQ.err;
    assign restartPending = stateQ.pending;
    assign field1Data     = stateQ.field1;
    assign field2Data     = stateQ.field2;

    // Checks on the bank behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Legal item one write
    sequence wrItemOne;
        clkEn && paramWrEn && !paramRdEn && paramAddr == `MFS_ADDR_FIELD1_ITEM && codeOk;
    endsequence

    // Legal item two write
    sequence wrItemTwo;
        clkEn && paramWrEn && !paramRdEn && paramAddr == `MFS_ADDR_FIELD2_ITEM && codeOk;
    endsequence

    // Mapped write, unlisted code
    sequence wrRefused;
        clkEn && paramWrEn && !paramRdEn && addrHit && !codeOk;
    endsequence

    // Restart with no write
    sequence plainRestart;
        clkEn && powerRestart && !paramWrEn;
    endsequence

    // Access taken
    sequence accTaken;
        clkEn && (paramWrEn || paramRdEn);
    endsequence

    // Two edges, no restart
    sequence noRestart2;
        !powerRestart [*2];
    endsequence

    // Active item held
    AST_ITEM_HELD_UNTIL_RESTART: assert property ( // R4
        (wrItemOne ##0 (paramWrData != stateQ.itemOneAct) ##0 noRestart2)
            |=> $stable(stateQ.itemOneAct))
        else $error("item selector took effect before restart");

    // Restart commits both
    AST_ITEM_RESTART_COMMIT: assert property ( // R4
        plainRestart |=> stateQ.itemOneAct == $past(stateQ.itemOnePend)
            && stateQ.itemTwoAct == $past(stateQ.itemTwoPend) && !restartPending)
        else $error("restart did not commit item selectors");

    // Stored, pending on difference
    AST_ITEM_WRITE_STORED: assert property ( // R1
        wrItemOne |=> stateQ.itemOnePend == $past(paramWrData)
            && restartPending == (stateQ.itemOnePend != stateQ.itemOneAct
            || stateQ.itemTwoPend != stateQ.itemTwoAct))
        else $error("item selector write not stored");

    // Item two stored
    AST_ITEM_TWO_STORED: assert property ( // R2
        wrItemTwo |=> stateQ.itemTwoPend == $past(paramWrData))
        else $error("second item selector write not stored");

    // Unlisted code refused
    AST_BAD_CODE_REJECT: assert property ( // R10
        wrRefused |=> paramErr && $stable(stateQ.directOne) && $stable(stateQ.commonOne)
            && $stable(stateQ.directTwo) && $stable(stateQ.commonTwo))
        else $error("unlisted code was accepted");

    // Write beside read refused
    AST_WR_RD_REFUSED: assert property ( // R10
        clkEn && paramWrEn && paramRdEn
            |=> paramErr && $stable(stateQ.itemOnePend) && $stable(stateQ.itemTwoPend))
        else $error("write beside a read was not refused");

    // Unmapped read
    AST_UNMAPPED_READ: assert property ( // R10
        clkEn && paramRdEn && !addrHit |=> paramErr && paramRdData == 16'h0000)
        else $error("unmapped read not flagged");

    // Common one read back
    AST_READ_COMMON_ONE: assert property ( // R8
        clkEn && paramRdEn && paramAddr == `MFS_ADDR_COMMON_ONE
            |=> paramRdData == stateQ.commonOne)
        else $error("common one selector read back wrong");

    // Common one route
    AST_ROUTE_CMN_ONE: assert property ( // R8
        clkEn && stateQ.directOne == 16'h000c && stateQ.commonOne == `MFS_CMN_TARGET_POS
            |=> field1Data == $past(targetPosition))
        else $error("common monitor one not routed");

    // Common two route
    AST_ROUTE_CMN_TWO: assert property ( // R9
        clkEn && stateQ.directTwo == 16'h000d && stateQ.commonTwo == `MFS_CMN_INIT_POS_HIGH
            |=> field2Data == $past(itemValues[`MFS_ITEM_INIT_POS_HIGH]))
        else $error("common monitor two not routed");

    // Option two route
    AST_ROUTE_OPTION: assert property ( // R7
        clkEn && stateQ.directOne == 16'h000f |=> field1Data == $past(optionItemTwo))
        else $error("option monitor two not routed");

    // Option one route
    AST_ROUTE_OPT_ONE: assert property ( // R7
        clkEn && stateQ.directOne == 16'h000e |=> field1Data == $past(optionItemOne))
        else $error("option monitor one not routed");

    // Item code 39, field two
    AST_ITEM_FIELD: assert property ( // R3
        clkEn && stateQ.directTwo == 16'h0000 && stateQ.itemTwoAct == 16'h0027
            |=> field2Data == $past(itemValues[39]))
        else $error("item code 39 not routed to field two");

    // Item code 5, field one
    AST_ITEM_FIELD_ONE: assert property ( // R1
        clkEn && stateQ.directOne == 16'h0006 && stateQ.itemOneAct == 16'h0005
            |=> field1Data == $past(itemValues[5]))
        else $error("item code 5 not routed to field one");

    // Ack one cycle, held while frozen
    AST_ACK_TIMING: assert property ( // R10
        accTaken |=> paramAck ##1 (!paramAck || $past(paramWrEn || paramRdEn || !clkEn)))
        else $error("access acknowledge timing wrong");

endmodule : mfs_monitor_select

// ==== mfs_params.svh ====
// Constants for the monitor field select register bank.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef MFS_PARAMS_SVH
`define MFS_PARAMS_SVH

// Parameter numbers of the selectors
`define MFS_ADDR_FIELD1_DIRECT   12'h84c
`define MFS_ADDR_FIELD2_DIRECT   12'h84d
`define MFS_ADDR_COMMON_ONE      12'h84e
`define MFS_ADDR_COMMON_TWO      12'h84f
`define MFS_ADDR_FIELD1_ITEM     12'h8fe
`define MFS_ADDR_FIELD2_ITEM     12'h8ff

// Reset values
`define MFS_RST_FIELD1_DIRECT    16'h0001
`define MFS_RST_FIELD2_DIRECT    16'h0000
`define MFS_RST_COMMON_ONE       16'h0000
`define MFS_RST_COMMON_TWO       16'h0000
`define MFS_RST_FIELD1_ITEM      16'h0001
`define MFS_RST_FIELD2_ITEM      16'h0000

// Selector code limits
`define MFS_ITEM_COUNT           40
`define MFS_ITEM_MAX             16'h0027
`define MFS_ITEM_HOLE            16'h0024
`define MFS_DIRECT_LAST_ITEM     16'h0006
`define MFS_DIRECT_FIRST_ROUTE   16'h000c
`define MFS_DIRECT_LAST_ROUTE    16'h000f
`define MFS_COMMON_ONE_MAX       16'h0004

// Item codes that common monitors reuse
`define MFS_ITEM_SPEED_CEILING   6'h13
`define MFS_ITEM_TORQUE_CEILING  6'h14
`define MFS_ITEM_INIT_POS_LOW    6'h17
`define MFS_ITEM_INIT_POS_HIGH   6'h18
`define MFS_ITEM_OPER_STATUS     6'h19
`define MFS_ITEM_INT_CMD_POS     6'h23
`define MFS_ITEM_POS_OFFSET      6'h26
`define MFS_ITEM_TARGET_SPEED    6'h27

// Common monitor codes
`define MFS_CMN_TARGET_POS       16'h0000
`define MFS_CMN_INT_CMD_POS      16'h0001
`define MFS_CMN_POS_OFFSET       16'h0002
`define MFS_CMN_TARGET_SPEED     16'h0003
`define MFS_CMN_SPEED_CEILING    16'h0004
`define MFS_CMN_TORQUE_CEILING   16'h0005
`define MFS_CMN_OPER_STATUS      16'h0006
`define MFS_CMN_INIT_POS_LOW     16'h0008
`define MFS_CMN_INIT_POS_HIGH    16'h0009

`endif

// ==== mfs_pkg.sv ====
// Types for the monitor field select register bank.
// Assumes nothing from mfs_params.svh; route codes are fixed here.
package mfs_pkg;

    typedef logic [15:0] mfs_code_t;
    typedef logic [31:0] mfs_word_t;

    // Field selector route codes
    typedef enum logic [3:0] {
        MFS_ROUTE_CMN_ONE = 4'b1100,
        MFS_ROUTE_CMN_TWO = 4'b1101,
        MFS_ROUTE_OPT_ONE = 4'b1110,
        MFS_ROUTE_OPT_TWO = 4'b1111
    } mfs_route_e;

    // Whole state of the register bank
    typedef struct packed {
        mfs_code_t itemOnePend;
        mfs_code_t itemTwoPend;
        mfs_code_t itemOneAct;
        mfs_code_t itemTwoAct;
        mfs_code_t directOne;
        mfs_code_t directTwo;
        mfs_code_t commonOne;
        mfs_code_t commonTwo;
        mfs_code_t rdData;
        logic      ack;
        logic      err;
        logic      pending;
        mfs_word_t field1;
        mfs_word_t field2;
    } mfs_state_s;

endpackage : mfs_pkg

// ==== mfs_sel_if.sv ====
// Selector bundle for one monitor field.
// Assumes the register bank drives it and a field mux reads it.
`timescale 1ns/10ps
interface mfs_sel_if;
    mfs_pkg::mfs_code_t itemSel;
    mfs_pkg::mfs_code_t directSel;
    mfs_pkg::mfs_code_t commonOneSel;
    mfs_pkg::mfs_code_t commonTwoSel;

    modport src  (output itemSel, output directSel, output commonOneSel, output commonTwoSel);
    modport sink (input itemSel, input directSel, input commonOneSel, input commonTwoSel);
endinterface : mfs_sel_if

// ==== tb_top.sv ====
// Self-checking bench for the monitor field select register bank.
// Assumes the design carries its own assertions; the model drives the port.
`timescale 1ns/10ps
`include "mfs_params.svh"
module tb_top;
    typedef struct packed {logic err; logic chk; logic [15:0] data;} mfs_note_s;
    logic              core_clk       = 1'b0;
    logic              rst            = 1'b1;
    logic              clkEn          = 1'b1;
    logic              powerRestart   = 1'b0;
    logic              paramWrEn;
    logic              paramRdEn;
    logic [11:0]       paramAddr;
    logic [15:0]       paramWrData;
    logic [15:0]       paramRdData;
    logic              paramAck;
    logic              paramErr;
    logic              restartPending;
    logic [39:0][31:0] itemValues;
    logic [31:0]       targetPosition;
    logic [31:0]       optionItemOne;
    logic [31:0]       optionItemTwo;
    logic [31:0]       field1Data;
    logic [31:0]       field2Data;
    logic [31:0]       last;
    logic [31:0]       f2;
    logic              bad;
    mfs_note_s         note;
    mfs_note_s         notes[$];
    integer            seed           = 32'h6579_a893;
    int                errors         = 0;
    int                cmpCount       = 0;
    int                cycles         = 0;

    // Clock at 8 ns
    always #4 core_clk = ~core_clk;

    mfs_ctrl_model model (.core_clk(core_clk), .paramWrEn(paramWrEn), .paramRdEn(paramRdEn),
        .paramAddr(paramAddr), .paramWrData(paramWrData));

    mfs_monitor_select uut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
        .powerRestart(powerRestart), .paramWrEn(paramWrEn), .paramRdEn(paramRdEn),
        .paramAddr(paramAddr), .paramWrData(paramWrData), .paramRdData(paramRdData),
        .paramAck(paramAck), .paramErr(paramErr), .restartPending(restartPending),
        .itemValues(itemValues), .targetPosition(targetPosition),
        .optionItemOne(optionItemOne), .optionItemTwo(optionItemTwo),
        .field1Data(field1Data), .field2Data(field2Data));

    // Single comparison point
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // Access plus its note for the answer watcher
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic e);
        model.acc(1'b1, 1'b0, a, d);
        notes.push_back('{e, 1'b0, 16'h0000});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [15:0] d, input logic e);
        model.acc(1'b0, 1'b1, a, 16'h0000);
        notes.push_back('{e, 1'b1, d});
    endtask : rd

    task automatic fld(input logic [31:0] e1, input logic [31:0] e2);
        @(negedge core_clk);
        check("field1Data", field1Data, e1);
        check("field2Data", field2Data, e2);
    endtask : fld

    task automatic restart();
        @(negedge core_clk);
        powerRestart = 1'b1;
        @(negedge core_clk);
        powerRestart = 1'b0;
        check("restartPending", 32'(restartPending), 32'h0000_0000);
    endtask : restart

    // Common monitor code to the quantity it names
    function automatic logic [31:0] cmnExp(input int k);
        case (k)
            0: return targetPosition;
            1: return itemValues[`MFS_ITEM_INT_CMD_POS];
            2: return itemValues[`MFS_ITEM_POS_OFFSET];
            3: return itemValues[`MFS_ITEM_TARGET_SPEED];
            4: return itemValues[`MFS_ITEM_SPEED_CEILING];
            5: return itemValues[`MFS_ITEM_TORQUE_CEILING];
            6: return itemValues[`MFS_ITEM_OPER_STATUS];
            8: return itemValues[`MFS_ITEM_INIT_POS_LOW];
            9: return itemValues[`MFS_ITEM_INIT_POS_HIGH];
            default: return 32'h0000_0000;
        endcase
    endfunction : cmnExp

    // Answer watcher takes the oldest note on each ack
    always @(negedge core_clk) begin
        if (paramAck === 1'b1) begin
            if (notes.size() == 0) begin
                check("unexpected paramAck", 32'h0000_0001, 32'h0000_0000);
            end else begin
                note = notes.pop_front();
                check("paramErr", 32'(paramErr), 32'(note.err));
                if (note.chk) check("paramRdData", 32'(paramRdData), 32'(note.data));
            end
        end
    end

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            check("timeout", 32'h0000_0001, 32'h0000_0000);
            wrap_up();
        end
    end

    // Main sequence
    initial begin
        for (int i = 0; i < 40; i++) itemValues[i] = $random(seed);
        targetPosition = $random(seed);
        optionItemOne  = $random(seed);
        optionItemTwo  = $random(seed);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        rd(`MFS_ADDR_FIELD1_ITEM, `MFS_RST_FIELD1_ITEM, 1'b0);
        rd(`MFS_ADDR_FIELD2_ITEM, `MFS_RST_FIELD2_ITEM, 1'b0);
        rd(`MFS_ADDR_FIELD1_DIRECT, `MFS_RST_FIELD1_DIRECT, 1'b0);
        rd(`MFS_ADDR_FIELD2_DIRECT, `MFS_RST_FIELD2_DIRECT, 1'b0);
        rd(`MFS_ADDR_COMMON_ONE, `MFS_RST_COMMON_ONE, 1'b0);
        rd(`MFS_ADDR_COMMON_TWO, `MFS_RST_COMMON_TWO, 1'b0);
        rd(12'h0850, 16'h0000, 1'b1);
        model.idle();
        fld(itemValues[1], itemValues[0]);
        $display("test reset_values done");
        wr(`MFS_ADDR_FIELD1_ITEM, 16'h0005, 1'b0);
        model.idle();
        check("restartPending", 32'(restartPending), 32'h0000_0001);
        fld(itemValues[1], itemValues[0]);
        rd(`MFS_ADDR_FIELD1_ITEM, 16'h0005, 1'b0);
        model.idle();
        restart();
        fld(itemValues[5], itemValues[0]);
        $display("test restart_commit done");
        last = itemValues[0];
        for (int c = 0; c <= 40; c++) begin
            bad = (c == 36) || (c == 40);
            wr(`MFS_ADDR_FIELD2_ITEM, 16'(c), bad);
            model.idle();
            restart();
            if (!bad) last = itemValues[c];
            fld(itemValues[5], last);
        end
        f2 = last;
        model.acc(1'b1, 1'b1, `MFS_ADDR_FIELD2_ITEM, 16'h0003);
        notes.push_back('{1'b1, 1'b1, 16'h0027});
        rd(`MFS_ADDR_FIELD2_ITEM, 16'h0027, 1'b0);
        $display("test item_codes done");
        // Controller rewrites the indirection selectors along with the item
        wr(`MFS_ADDR_FIELD1_DIRECT, 16'h000c, 1'b0);
        for (int k = 0; k <= 5; k++) begin
            wr(`MFS_ADDR_COMMON_ONE, 16'(k), k == 5);
            model.idle();
            if (k < 5) last = cmnExp(k);
            fld(last, f2);
        end
        wr(`MFS_ADDR_FIELD1_DIRECT, 16'h000d, 1'b0);
        for (int k = 5; k <= 9; k++) begin
            wr(`MFS_ADDR_COMMON_TWO, 16'(k), k == 7);
            model.idle();
            if (k != 7) last = cmnExp(k);
            fld(last, f2);
        end
        wr(`MFS_ADDR_FIELD1_DIRECT, 16'h000e, 1'b0);
        model.idle();
        fld(optionItemOne, f2);
        wr(`MFS_ADDR_FIELD1_DIRECT, 16'h000f, 1'b0);
        for (int k = 7; k <= 11; k++) wr(`MFS_ADDR_FIELD1_DIRECT, 16'(k), 1'b1);
        wr(`MFS_ADDR_FIELD2_DIRECT, 16'h0010, 1'b1);
        model.idle();
        fld(optionItemTwo, f2);
        wr(`MFS_ADDR_FIELD1_DIRECT, 16'h0006, 1'b0);
        wr(`MFS_ADDR_FIELD2_DIRECT, 16'h000d, 1'b0);
        model.idle();
        fld(itemValues[5], cmnExp(9));
        $display("test routing done");
        model.acc(1'b0, 1'b1, `MFS_ADDR_COMMON_TWO, 16'h0000);
        clkEn = 1'b0;
        last = itemValues[5];
        itemValues[5] = $random(seed);
        repeat (3) @(negedge core_clk);
        check("field1Data", field1Data, last);
        notes.push_back('{1'b0, 1'b1, 16'h0009});
        clkEn = 1'b1;
        model.idle();
        fld(itemValues[5], cmnExp(9));
        repeat (20) begin
            @(negedge core_clk);
            for (int i = 0; i < 40; i++) itemValues[i] = $random(seed);
            fld(itemValues[5], cmnExp(9));
        end
        $display("test freeze_random done");
        @(negedge core_clk);
        rst = 1'b1;
        @(negedge core_clk);
        rst = 1'b0;
        rd(`MFS_ADDR_FIELD1_ITEM, `MFS_RST_FIELD1_ITEM, 1'b0);
        model.idle();
        fld(itemValues[1], itemValues[0]);
        check("notes left", 32'(notes.size()), 32'h0000_0000);
        $display("test second_reset done");
        wrap_up();
    end
endmodule : tb_top
